//--- src/spb_pkg.sv
// constants, register map and state types for the serial port receive/config block
// assumes an 8-bit special function register bus on the core clock
package spb_pkg;

  // register byte addresses on the special function register bus
  localparam logic [7:0] SPB_ADDR_TX_BUF = 8'h9a;
  localparam logic [7:0] SPB_ADDR_RX_BUF = 8'h9b;
  localparam logic [7:0] SPB_ADDR_CFG_ONE = 8'he8;

  // reset values and the slave fill byte
  localparam logic [7:0] SPB_CFG_ONE_RESET = 8'h10;
  localparam logic [7:0] SPB_RX_BUF_RESET = 8'h00;
  localparam logic [7:0] SPB_TX_BUF_RESET = 8'h00;
  localparam logic [7:0] SPB_SLAVE_FILL = 8'h00;

  // field positions in serial_port_config_one
  localparam int SPB_IRQ_SEL_BIT = 5;
  localparam int SPB_AUTO_SS_BIT = 4;
  localparam int SPB_SS_IN_EN_BIT = 3;
  localparam int SPB_OVF_REPLACE_BIT = 2;
  localparam int SPB_RATE_LSB = 0;
  localparam logic [7:0] SPB_CFG_ONE_WMASK = 8'h3f;

  // serial clock: core clock divided by 8 << rate code, toggled every half period
  localparam int SPB_SCLK_MIN_DIVIDE = 8;
  localparam int SPB_HALF_MIN = SPB_SCLK_MIN_DIVIDE / 2;
  localparam logic [4:0] SPB_LAST_EDGE = 5'h0f;
  localparam logic [2:0] SPB_LAST_BIT = 3'h7;

  // receive fifo geometry
  localparam int SPB_FIFO_WIDTH = 8;
  localparam int SPB_FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    SPB_IDLE,
    SPB_SHIFT,
    SPB_GAP
  } spb_master_state_e;

endpackage : spb_pkg

//--- src/spb_rx_config.sv
// serial port receive buffer, first configuration register and shift engines
// assumes a synchronous sfr bus and pins already synchronous to mclk
//
// Summary of operation
// - reading receive buffer moves one byte from fifo output into it
// - every complete received byte is pushed into the receive fifo, unless it is full with overflow replace 0
// - trigger select 0: interrupt raised when receive data is available
// - trigger select 1: interrupt raised when transmit buffer is empty
// - master, auto select clear: chip select held low continuously
// - master, auto select set: chip select low only during a byte
// - master, auto select set: low across a continuous burst, then high
// - slave, select input enable set: select pin gates the slave
// - overflow replace 0: byte arriving into full buffer is dropped
// - overflow replace 1: arriving byte evicts the oldest byte held in the fifo
// - rate code 0..3 divides core clock by 8, 16, 32 or 64
// - master select 0 means slave, 1 means master
// - continuous mode keeps select low until buffer and shifter empty
`timescale 1ns/1ns
`default_nettype none

module spb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] wr_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // a full fifo still takes a word when one leaves in the same cycle
  assign full = (count_q == (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign in_ready = !full || out_ready;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_q];

  // storage, no reset needed on the data words
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : spb_fifo

module spb_rx_config #(
  parameter int FIFO_DEPTH = spb_pkg::SPB_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic spi_enable,
  input wire logic master_select,
  input wire logic continuous_transfer_enable,
  input wire logic clk_polarity,
  input wire logic clk_phase,
  output logic spi_irq,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe
);
  import spb_pkg::*;

  // half period of the serial clock minus one, in core cycles
  function automatic logic [5:0] half_limit(input logic [1:0] rate);
    half_limit = (6'(SPB_HALF_MIN) << rate) - 6'h01;
  endfunction : half_limit

  logic [7:0] cfg_one_q;
  logic [7:0] rx_buf_q;
  logic [7:0] tx_data_q;
  logic tx_full_q;
  logic [7:0] sfr_rdata_q;
  logic spi_irq_q;
  logic irq_sel;
  logic auto_ss;
  logic ss_in_en;
  logic ovf_replace;
  logic [1:0] rate;
  logic sw_rx_read;
  logic rx_push;
  logic [7:0] rx_push_data;
  logic fifo_out_valid;
  logic fifo_pop;
  logic fifo_full;
  logic [7:0] fifo_out_data;
  logic master_en;
  logic master_load;
  logic slave_load;
  logic m_push;
  logic [7:0] m_push_data;
  logic s_push;
  logic [7:0] s_push_data;

  assign irq_sel = cfg_one_q[SPB_IRQ_SEL_BIT];
  assign auto_ss = cfg_one_q[SPB_AUTO_SS_BIT];
  assign ss_in_en = cfg_one_q[SPB_SS_IN_EN_BIT];
  assign ovf_replace = cfg_one_q[SPB_OVF_REPLACE_BIT];
  assign rate = cfg_one_q[SPB_RATE_LSB +: 2];
  assign master_en = spi_enable && master_select;
  assign sw_rx_read = sfr_rd && (sfr_addr == SPB_ADDR_RX_BUF);

  // config register, reserved bits never stored so they read back zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_one_q <= SPB_CFG_ONE_RESET;
    end else if (sfr_wr && sfr_addr == SPB_ADDR_CFG_ONE) begin
      cfg_one_q <= sfr_wdata & SPB_CFG_ONE_WMASK;
    end
  end

  // transmit holding byte; a write in the load cycle wins so no byte is lost
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_data_q <= SPB_TX_BUF_RESET;
      tx_full_q <= 1'b0;
    end else if (sfr_wr && sfr_addr == SPB_ADDR_TX_BUF) begin
      tx_data_q <= sfr_wdata;
      tx_full_q <= 1'b1;
    end else if (master_load || slave_load) begin
      tx_full_q <= 1'b0;
    end
  end

  // receive fifo: software reads drain it, so it can really fill
  assign rx_push = m_push || s_push;
  assign rx_push_data = m_push ? m_push_data : s_push_data;
  // on overflow either drop the newcomer or evict the oldest byte
  assign fifo_pop = (sw_rx_read && fifo_out_valid)
                  || (rx_push && fifo_full && ovf_replace);

  spb_fifo #(
    .WIDTH(SPB_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(rx_push),
    .in_ready(),
    .in_data(rx_push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .full(fifo_full)
  );

  // receive buffer register, loaded from the fifo head by a read
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_buf_q <= SPB_RX_BUF_RESET;
    end else if (sw_rx_read && fifo_out_valid) begin
      rx_buf_q <= fifo_out_data;
    end
  end

  // read data, one cycle after the strobe; transmit buffer is write only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        SPB_ADDR_RX_BUF: sfr_rdata_q <= fifo_out_valid ? fifo_out_data : rx_buf_q;
        SPB_ADDR_CFG_ONE: sfr_rdata_q <= cfg_one_q;
        default: sfr_rdata_q <= 8'h00;
      endcase
    end
  end
  assign sfr_rdata = sfr_rdata_q;

  // interrupt level follows the selected source
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      spi_irq_q <= 1'b0;
    end else if (irq_sel) begin
      spi_irq_q <= !tx_full_q;
    end else begin
      spi_irq_q <= fifo_out_valid;
    end
  end
  assign spi_irq = spi_irq_q;

  // master engine
  spb_master_state_e state_q;
  logic [5:0] half_cnt_q;
  logic [4:0] edge_cnt_q;
  logic sclk_q;
  logic mosi_q;
  logic ss_n_q;
  logic [7:0] m_tx_q;
  logic [7:0] m_rx_q;
  logic m_tick;
  logic m_last;
  logic m_sample;

  // at or past the limit, so a rate cut mid-gap cannot run the counter round
  assign m_tick = (state_q != SPB_IDLE) && (half_cnt_q >= half_limit(rate));
  assign m_last = m_tick && state_q == SPB_SHIFT && edge_cnt_q == SPB_LAST_EDGE;
  // even edges lead; phase 0 samples on leading, phase 1 on trailing
  assign m_sample = (edge_cnt_q[0] == clk_phase);
  assign master_load = master_en && tx_full_q
                     && (state_q == SPB_IDLE || (m_last && continuous_transfer_enable));
  assign m_push = m_last;
  assign m_push_data = clk_phase ? {m_rx_q[6:0], miso_i} : m_rx_q;

  // sequencing, divider and shift registers of the master
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SPB_IDLE;
      half_cnt_q <= '0;
      edge_cnt_q <= '0;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      m_tx_q <= 8'h00;
      m_rx_q <= 8'h00;
    end else if (!master_en) begin
      state_q <= SPB_IDLE;
      half_cnt_q <= '0;
      sclk_q <= clk_polarity;
    end else begin
      half_cnt_q <= m_tick ? '0 : half_cnt_q + 6'h01;
      if (master_load) begin
        state_q <= SPB_SHIFT;
        half_cnt_q <= '0;
        edge_cnt_q <= '0;
        sclk_q <= clk_polarity;
        m_tx_q <= tx_data_q;
        if (!clk_phase) begin
          mosi_q <= tx_data_q[7];
        end
      end else if (m_last) begin
        state_q <= SPB_GAP;
        sclk_q <= ~sclk_q;
      end else if (state_q == SPB_GAP && m_tick) begin
        state_q <= SPB_IDLE;
      end else if (state_q == SPB_IDLE) begin
        half_cnt_q <= '0;
        sclk_q <= clk_polarity;
      end else if (state_q == SPB_SHIFT && m_tick) begin
        sclk_q <= ~sclk_q;
        edge_cnt_q <= edge_cnt_q + 5'h01;
        if (m_sample) begin
          m_rx_q <= {m_rx_q[6:0], miso_i};
        end else begin
          mosi_q <= clk_phase ? m_tx_q[7] : m_tx_q[6];
          m_tx_q <= {m_tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // chip select: manual low, or low while a byte or burst is shifting
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ss_n_q <= 1'b1;
    end else if (!master_en) begin
      ss_n_q <= 1'b1;
    end else if (!auto_ss) begin
      ss_n_q <= 1'b0;
    end else begin
      ss_n_q <= !(state_q == SPB_SHIFT || master_load);
    end
  end

  assign sclk_o = sclk_q;
  assign sclk_oe = master_en;
  assign mosi_o = mosi_q;
  assign mosi_oe = master_en;
  assign ss_n_o = ss_n_q;
  assign ss_n_oe = master_en;

  // slave engine, clocked by mclk and stepped by detected edges of the incoming serial clock
  logic sl_active;
  logic sl_active_q;
  logic sclk_prev_q;
  logic sl_edge;
  logic sl_lead;
  logic sl_sample;
  logic sl_shift;
  logic sl_skip_q;
  logic [2:0] sl_cnt_q;
  logic [7:0] sl_rx_q;
  logic [7:0] sl_tx_q;
  logic miso_q;
  logic [7:0] sl_next;

  // without select input enable the slave is always selected
  assign sl_active = spi_enable && !master_select && (!ss_in_en || !ss_n_i);
  assign sl_edge = sl_active && (sclk_i != sclk_prev_q);
  assign sl_lead = (sclk_i != clk_polarity);
  assign sl_sample = sl_edge && (sl_lead ^ clk_phase);
  assign sl_shift = sl_edge && !(sl_lead ^ clk_phase);
  assign s_push = sl_sample && sl_cnt_q == SPB_LAST_BIT;
  assign s_push_data = {sl_rx_q[6:0], mosi_i};
  assign slave_load = (sl_active && !sl_active_q) || s_push;
  assign sl_next = tx_full_q ? tx_data_q : SPB_SLAVE_FILL;

  // slave shifter; a reload in phase 0 skips the old byte's closing edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sl_active_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      sl_skip_q <= 1'b0;
      sl_cnt_q <= '0;
      sl_rx_q <= 8'h00;
      sl_tx_q <= 8'h00;
      miso_q <= 1'b0;
    end else begin
      sl_active_q <= sl_active;
      sclk_prev_q <= sclk_i;
      if (!sl_active) begin
        sl_cnt_q <= '0;
        sl_skip_q <= 1'b0;
      end else if (slave_load) begin
        sl_tx_q <= sl_next;
        sl_cnt_q <= '0;
        sl_skip_q <= s_push && !clk_phase;
        if (!clk_phase) begin
          miso_q <= sl_next[7];
        end
      end else if (sl_sample) begin
        sl_rx_q <= {sl_rx_q[6:0], mosi_i};
        sl_cnt_q <= sl_cnt_q + 3'h1;
      end else if (sl_shift && sl_skip_q) begin
        sl_skip_q <= 1'b0;
      end else if (sl_shift) begin
        miso_q <= clk_phase ? sl_tx_q[7] : sl_tx_q[6];
        sl_tx_q <= {sl_tx_q[6:0], 1'b0};
      end
    end
  end

  assign miso_o = miso_q;
  assign miso_oe = sl_active;

endmodule : spb_rx_config

`default_nettype wire

//--- test/spb_rx_config_props.sv
// concurrent checks on the serial port block: read-back and master framing
// bound to spb_rx_config, sees only its ports, single core clock domain
`timescale 1ns/1ns
`default_nettype none
module spb_rx_config_props import spb_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic spi_enable,
  input wire logic master_select,
  input wire logic sclk_o,
  input wire logic sclk_oe,
  input wire logic ss_n_o,
  input wire logic ss_n_oe,
  input wire logic miso_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [7:0] edge_q;

  // sclk edges since select fell; a frame has to close on a byte boundary
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      edge_q <= 8'h00;
    end else if ($fell(ss_n_o)) begin
      edge_q <= 8'h00;
    end else if (sclk_oe && $changed(sclk_o)) begin
      edge_q <= edge_q + 8'h01;
    end
  end

  AST_SCLK_OE: assert property (sclk_oe == (spi_enable && master_select))
    else $error("clock enable does not follow master mode");
  AST_SS_OE: assert property (ss_n_oe == (spi_enable && master_select))
    else $error("select enable does not follow master mode");
  AST_MISO_OFF: assert property (spi_enable && master_select |-> !miso_oe)
    else $error("master drives miso");
  AST_CFG_RSVD: assert property (sfr_rd && sfr_addr == SPB_ADDR_CFG_ONE |=>
    sfr_rdata[7:6] == 2'b00) else $error("reserved config bits read nonzero");
  AST_RDATA_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  AST_SCLK_RATE: assert property (sclk_oe && $changed(sclk_o) |=>
    $stable(sclk_o) [*3]) else $error("serial clock half period under four");
  AST_SCLK_IN_FRAME: assert property (sclk_oe && $changed(sclk_o) |->
    !$past(ss_n_o)) else $error("serial clock toggled while deselected");
  AST_FRAME_BYTES: assert property ($rose(ss_n_o) |=> edge_q[3:0] == 4'h0)
    else $error("select released inside a byte");
  AST_GAP_QUIET: assert property ($rose(ss_n_o) |=> $stable(sclk_o) [*3])
    else $error("serial clock active right after release");
endmodule : spb_rx_config_props

bind spb_rx_config spb_rx_config_props i_spb_rx_config_props (.mclk(mclk),
  .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .spi_enable(spi_enable), .master_select(master_select), .sclk_o(sclk_o),
  .sclk_oe(sclk_oe), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .miso_oe(miso_oe));
`default_nettype wire

//--- test/spb_ext_slave.sv
// behavioural external slave: answers a known byte sequence msb first, keeps the last byte in
// assumes clock idle low, sampling on the leading edge
`timescale 1ns/1ns
`default_nettype none
module spb_ext_slave (
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] got
);
  logic [7:0] pat;
  logic [7:0] sh;
  logic [2:0] nb;
  initial begin
    pat = 8'ha5;
    nb = 3'h0;
    miso = 1'b1;
    sh = 8'h00;
    got = 8'h00;
  end
  // selection restarts at the top bit
  always @(negedge ss_n) begin
    nb = 3'h0;
    miso = pat[7];
  end
  // leading edge: count a sample, step the pattern after eight
  always @(posedge sclk) if (!ss_n) begin
    sh = {sh[6:0], mosi};
    nb = nb + 3'h1;
    if (nb == 3'h0) begin
      pat = pat + 8'h13;
      got = sh;
    end
  end
  // trailing edge presents the next bit
  always @(negedge sclk) if (!ss_n) miso = pat[3'h7 - nb];
  // released: invert so a stale bit never passes for data
  always @(posedge ss_n) miso = ~miso;
endmodule : spb_ext_slave
`default_nettype wire

//--- test/tb_spb_rx_config.sv
// self-checking bench: master mode transfers against the external slave model,
// then two slave-mode bytes, one selected and one deselected, with the bench playing the external master
// assumes spb_pkg, the design and spb_ext_slave are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_spb_rx_config import spb_pkg::*;;
  logic mclk, reset_n, sfr_wr, sfr_rd, spi_enable, master_select, cont_en, slave_miso;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, q, slave_got, sg;
  logic m_sclk, m_mosi, m_ss;
  logic spi_irq, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe;
  wire logic sclk_w, mosi_w, miso_w, ss_w;
  int bad_count, n_tests, k, half;
  // pins resolved from both ends; released lines fall to the bench's own master drivers, miso to the external slave model
  assign sclk_w = sclk_oe ? sclk_o : m_sclk;
  assign ss_w = ss_n_oe ? ss_n_o : m_ss;
  assign mosi_w = mosi_oe ? mosi_o : m_mosi;
  assign miso_w = miso_oe ? miso_o : slave_miso;
  spb_rx_config #(.FIFO_DEPTH(SPB_FIFO_DEPTH)) i_spb_rx_config (.mclk(mclk),
    .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .spi_enable(spi_enable),
    .master_select(master_select), .continuous_transfer_enable(cont_en),
    .clk_polarity(1'b0), .clk_phase(1'b0), .spi_irq(spi_irq), .sclk_i(sclk_w),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
    .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));
  spb_ext_slave i_spb_ext_slave (.sclk(sclk_w), .ss_n(ss_w), .mosi(mosi_w),
    .miso(slave_miso), .got(slave_got));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask : chk
  task automatic close_out;
    $display("counts: %0d compared, %0d mismatched", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // strobes rise one step after an edge and drop after the next; one idle cycle follows
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge mclk);
    #1 sfr_wr = 1'b0;
    @(posedge mclk);
    #1;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge mclk);
    #1 sfr_rd = 1'b0;
    q = sfr_rdata;
    chk(q, e);
    @(posedge mclk);
    #1;
  endtask : rdc
  function automatic logic [7:0] rxb(input int n);
    return 8'ha5 + 8'h13 * n[7:0];
  endfunction : rxb
  // one transfer: count sclk edges, note the first half period, watch select
  task automatic xfer(input logic [7:0] d, input int ne, input logic ss_end);
    int e, n, t1, hi;
    logic s;
    wr(SPB_ADDR_TX_BUF, d);
    s = sclk_o;
    e = 0;
    hi = 0;
    t1 = 0;
    for (n = 0; n < 3000 && e < ne; n++) begin
      @(posedge mclk);
      #1;
      if (e > 0 && ss_n_o !== 1'b0) hi++;
      if (sclk_o !== s) begin
        e++;
        s = sclk_o;
        if (e == 1) t1 = n;
        if (e == 2) half = n - t1;
      end
    end
    if (e < ne) begin
      chk(8'(e), 8'(ne));
      close_out();
    end
    // outlast the closing gap of the slowest rate before the next write
    repeat (40) @(posedge mclk);
    #1;
    chk(8'(hi), 8'h00);
    chk({7'h0, ss_n_o}, {7'h0, ss_end});
    chk(slave_got, d);
    k++;
  endtask : xfer
  // external master, idle low, sampling on rising edges; miso taken just before each rise
  task automatic sbyte(input logic [7:0] d, output logic [7:0] got);
    for (int b = 7; b >= 0; b--) begin
      m_mosi = d[b];
      repeat (4) @(posedge mclk);
      #1 got[b] = miso_w;
      m_sclk = 1'b1;
      repeat (4) @(posedge mclk);
      #1 m_sclk = 1'b0;
    end
    repeat (4) @(posedge mclk);
    #1;
  endtask : sbyte
  initial begin
    reset_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    spi_enable = 1'b1;
    master_select = 1'b1;
    cont_en = 1'b0;
    m_sclk = 1'b0;
    m_mosi = 1'b0;
    m_ss = 1'b1;
    bad_count = 0;
    n_tests = 0;
    k = 0;
    half = 0;
    repeat (12) @(posedge mclk);
    #1 reset_n = 1'b1;
    // defaults, reserved bits, an unmapped place
    rdc(SPB_ADDR_CFG_ONE, 8'h10);
    rdc(SPB_ADDR_RX_BUF, 8'h00);
    rdc(8'h55, 8'h00);
    wr(SPB_ADDR_CFG_ONE, 8'hff);
    rdc(SPB_ADDR_CFG_ONE, 8'h3f);
    $display("test registers done");
    // manual select with the transmit-empty interrupt, then receive-data interrupt
    wr(SPB_ADDR_CFG_ONE, 8'h20);
    chk({7'h0, spi_irq}, 8'h01);
    chk({7'h0, ss_n_o}, 8'h00);
    xfer(8'h3c, 16, 1'b0);
    wr(SPB_ADDR_CFG_ONE, 8'h10);
    chk({7'h0, spi_irq}, 8'h01);
    rdc(SPB_ADDR_RX_BUF, rxb(0));
    chk({7'h0, spi_irq}, 8'h00);
    $display("test select and interrupt done");
    // every rate code, then the bytes they brought in
    for (int r = 0; r < 4; r++) begin
      wr(SPB_ADDR_CFG_ONE, 8'h10 | 8'(r));
      xfer(8'(r), 16, 1'b1);
      chk(8'(half), 8'(4 << r));
    end
    for (int i = 1; i < 5; i++) rdc(SPB_ADDR_RX_BUF, rxb(i));
    $display("test rates done");
    // two-byte burst keeps select low throughout
    wr(SPB_ADDR_CFG_ONE, 8'h10);
    cont_en = 1'b1;
    wr(SPB_ADDR_TX_BUF, 8'h11);
    xfer(8'h22, 32, 1'b1);
    k++;
    cont_en = 1'b0;
    for (int i = 5; i < 7; i++) rdc(SPB_ADDR_RX_BUF, rxb(i));
    $display("test burst done");
    // overfill the fifo: keep the old bytes, then evict the oldest
    for (int m = 0; m < 2; m++) begin
      wr(SPB_ADDR_CFG_ONE, m ? 8'h14 : 8'h10);
      for (int i = 0; i < 17; i++) xfer(8'h5a, 16, 1'b1);
      for (int i = 0; i < 16; i++) rdc(SPB_ADDR_RX_BUF, rxb(k - 17 + m + i));
    end
    rdc(SPB_ADDR_RX_BUF, rxb(k - 1));
    $display("test overflow done");
    // slave with select input enable: selected byte lands, deselected byte is ignored
    wr(SPB_ADDR_CFG_ONE, 8'h18);
    master_select = 1'b0;
    wr(SPB_ADDR_TX_BUF, 8'h96);
    m_ss = 1'b0;
    sbyte(8'h6b, sg);
    m_ss = 1'b1;
    chk(sg, 8'h96);
    rdc(SPB_ADDR_RX_BUF, 8'h6b);
    sbyte(8'hff, sg);
    chk({7'h0, miso_oe}, 8'h00);
    rdc(SPB_ADDR_RX_BUF, 8'h6b);
    $display("test slave select done");
    close_out();
  end
endmodule : tb_spb_rx_config
`default_nettype wire
